// >>> core/see_device.sv
`timescale 1ns/100ps
// memory end: decodes frames, holds array, times programming
module see_device #(
    parameter int WRITE_CYC = see_pkg::WRITE_TIME_CYC
) (
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    see_if.dev        lnk,
    output logic      o_busy,
    output logic      o_prog_enabled
);
    typedef enum logic [2:0] {S_IDLE, S_HDR, S_WDATA, S_RDATA, S_STATUS, S_WAIT} see_st_type;

    // two-flop sync of all link inputs
    logic [3:0] s1_r, s2_r, s3_r;
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_r <= 4'hF;
            s2_r <= 4'hF;
            s3_r <= 4'hF;
        end else begin
            s1_r <= {lnk.chip_select_n, lnk.serial_clock_n, lnk.serial_data_in, lnk.reset_pin};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    wire cs_n = s2_r[3];
    wire sk = s2_r[2];
    wire di = s2_r[1];
    wire rp = s2_r[0];
    wire cs_fall = s3_r[3] & ~cs_n;
    wire cs_rise = ~s3_r[3] & cs_n;
    wire sk_rise = ~s3_r[2] & sk;
    wire sk_fall = s3_r[2] & ~sk;

    logic [15:0] mem_r [0:see_pkg::WORDS-1];
    logic [15:0] page_r [0:see_pkg::PAGE-1];
    logic [see_pkg::PAGE-1:0] pvalid_r;
    see_st_type st_r;
    logic [5:0] cnt_r;
    logic [15:0] sh_r;
    logic [9:0] addr_r;
    logic [5:0] op_r;
    logic wen_r, busy_r, do_r, oe_r;
    logic [16:0] tmr_r;
    logic [9:0] paddr_r;

    // shifter and sequencer on synchronised clock edges
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= S_IDLE;
            cnt_r <= 6'h00;
            sh_r <= 16'h0000;
            addr_r <= 10'h000;
            op_r <= 6'h00;
            wen_r <= 1'b0;
            busy_r <= 1'b0;
            tmr_r <= 17'h00000;
            pvalid_r <= '0;
            paddr_r <= 10'h000;
            do_r <= 1'b1;
            oe_r <= 1'b0;
        end else begin
            // programming timer and abort
            if (busy_r) begin
                if (rp) begin
                    busy_r <= 1'b0;
                end else if (tmr_r == 17'(WRITE_CYC - 1)) begin
                    busy_r <= 1'b0;
                    for (int k = 0; k < see_pkg::PAGE; k++) begin
                        if (pvalid_r[k]) begin
                            mem_r[{paddr_r[9:3], 3'(k)}] <= page_r[k];
                        end
                    end
                end
                tmr_r <= tmr_r + 17'h00001;
            end
            if (cs_rise) begin
                oe_r <= 1'b0;
                // page programming starts on deselect after whole words
                if (st_r == S_WDATA && op_r == see_pkg::OP_PAGE && cnt_r == 6'(see_pkg::HDR_BITS)
                    && pvalid_r != '0 && wen_r && !rp && !busy_r) begin
                    busy_r <= 1'b1;
                    tmr_r <= 17'h00000;
                end else if (!busy_r) begin
                    pvalid_r <= '0;
                end
                st_r <= S_IDLE;
            end else if (cs_fall) begin
                cnt_r <= 6'h00;
                if (sk) begin
                    st_r <= busy_r ? S_WAIT : S_HDR;
                    if (!busy_r) pvalid_r <= '0;
                end else begin
                    st_r <= S_STATUS;
                    oe_r <= 1'b1;
                    do_r <= ~busy_r;
                end
            end else begin
                case (st_r)
                    S_STATUS: begin
                        do_r <= ~busy_r;
                        if (sk_rise && di) begin
                            oe_r <= 1'b0;
                            st_r <= busy_r ? S_WAIT : S_HDR;
                            sh_r <= 16'h0001;
                            cnt_r <= 6'h01;
                        end
                    end
                    S_HDR: if (sk_rise) begin
                        sh_r <= {sh_r[14:0], di};
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r == 6'(see_pkg::HDR_BITS - 1)) begin
                            op_r <= sh_r[14:9];
                            addr_r <= {sh_r[8:7], sh_r[6:0], di};
                            cnt_r <= 6'h00;
                            if (sh_r[14:9] == see_pkg::OP_READ) begin
                                st_r <= S_RDATA;
                            end else if (sh_r[14:9] == see_pkg::OP_WRITE || sh_r[14:9] == see_pkg::OP_PAGE) begin
                                st_r <= S_WDATA;
                            end else begin
                                if (sh_r[14:7] == {see_pkg::OP_CTRL, see_pkg::CTRL_EN}) wen_r <= 1'b1;
                                if (sh_r[14:7] == {see_pkg::OP_CTRL, see_pkg::CTRL_DIS}) wen_r <= 1'b0;
                                st_r <= S_WAIT;
                            end
                        end
                    end
                    S_WDATA: if (sk_rise) begin
                        sh_r <= {sh_r[14:0], di};
                        cnt_r <= (cnt_r == 6'(see_pkg::HDR_BITS)) ? 6'h01 : cnt_r + 6'h01;
                        if (cnt_r == 6'(see_pkg::HDR_BITS - 1)) begin
                            if (op_r == see_pkg::OP_WRITE) begin
                                st_r <= S_WAIT;
                                if (wen_r && !rp) begin
                                    busy_r <= 1'b1;
                                    tmr_r <= 17'h00000;
                                    page_r[addr_r[2:0]] <= {sh_r[14:0], di};
                                    pvalid_r <= 8'(1) << addr_r[2:0];
                                    paddr_r <= addr_r;
                                end
                            end else begin
                                page_r[addr_r[2:0]] <= {sh_r[14:0], di};
                                pvalid_r[addr_r[2:0]] <= 1'b1;
                                paddr_r <= addr_r;
                                addr_r <= {addr_r[9:3], addr_r[2:0] + 3'h1};
                            end
                        end
                    end
                    S_RDATA: if (sk_fall) begin
                        oe_r <= 1'b1;
                        if (cnt_r == 6'h00) begin
                            do_r <= mem_r[addr_r][15];
                            sh_r <= {mem_r[addr_r][14:0], 1'b0};
                            addr_r <= addr_r + 10'h001;
                        end else begin
                            do_r <= sh_r[15];
                            sh_r <= {sh_r[14:0], 1'b0};
                        end
                        cnt_r <= (cnt_r == 6'(see_pkg::HDR_BITS - 1)) ? 6'h00 : cnt_r + 6'h01;
                    end
                    default: ;
                endcase
            end
        end
    end

    // outputs
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lnk.serial_data_out <= 1'b1;
            lnk.serial_data_out_oe <= 1'b0;
            lnk.ready_n_busy <= 1'b1;
            o_busy <= 1'b0;
            o_prog_enabled <= 1'b0;
        end else begin
            lnk.serial_data_out <= do_r;
            lnk.serial_data_out_oe <= oe_r & ~cs_n;
            lnk.ready_n_busy <= ~busy_r;
            o_busy <= busy_r;
            o_prog_enabled <= wen_r;
        end
    end
endmodule // see_device

// >>> core/see_host.sv
`timescale 1ns/100ps
// host end: runs one instruction per request
module see_host (
    input  wire logic        i_sys_clk,
    input  wire logic        i_sys_rst,
    see_if.hst               lnk,
    input  wire logic        i_req,
    input  wire logic [2:0]  i_cmd,
    input  wire logic [9:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [3:0]  i_nwords,
    input  wire logic        i_prot,
    output logic             o_ack,
    output logic             o_rvalid,
    output logic [15:0]      o_rdata,
    output logic             o_ready,
    output logic             o_dev_busy
);
    typedef enum logic [1:0] {H_IDLE, H_GAP, H_SHIFT, H_TAIL} see_hst_type;
    see_hst_type st_r;
    logic [4:0] div_r;
    logic [5:0] bit_r;
    logic [31:0] sh_r;
    logic [15:0] rx_r;
    logic [3:0] words_r;
    see_pkg::see_cmd_type cmd_r;
    logic [1:0] rs1_r, rs2_r;
    logic rd_pend_r;   // a read word waits for its last bit

    // sync device outputs
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rs1_r <= 2'h3;   // idle levels: ready, output high
            rs2_r <= 2'h3;
        end else begin
            rs1_r <= {lnk.ready_n_busy, lnk.serial_data_out};
            rs2_r <= rs1_r;
        end
    end

    function automatic logic [7:0] op_of(input see_pkg::see_cmd_type c, input logic [9:0] a);
        case (c)
            see_pkg::CMD_WRITE: op_of = {see_pkg::OP_WRITE, a[9:8]};
            see_pkg::CMD_PAGE: op_of = {see_pkg::OP_PAGE, a[9:8]};
            see_pkg::CMD_EN: op_of = {see_pkg::OP_CTRL, see_pkg::CTRL_EN};
            see_pkg::CMD_DIS: op_of = {see_pkg::OP_CTRL, see_pkg::CTRL_DIS};
            default: op_of = {see_pkg::OP_READ, a[9:8]};
        endcase
    endfunction

    // frame engine with divided serial clock
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= H_GAP;
            div_r <= 5'h00;
            bit_r <= 6'h00;
            sh_r <= 32'h00000000;
            rx_r <= 16'h0000;
            words_r <= 4'h0;
            cmd_r <= see_pkg::CMD_READ;
            rd_pend_r <= 1'b0;
            lnk.chip_select_n <= 1'b1;
            lnk.serial_clock_n <= 1'b1;
            lnk.serial_data_in <= 1'b0;
            lnk.reset_pin <= 1'b1;
            o_ack <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 16'h0000;
            o_ready <= 1'b0;
            o_dev_busy <= 1'b0;
        end else begin
            o_ack <= 1'b0;
            o_rvalid <= 1'b0;
            o_dev_busy <= ~rs2_r[1];
            case (st_r)
                H_GAP: begin
                    lnk.chip_select_n <= 1'b1;
                    lnk.serial_clock_n <= 1'b1;
                    div_r <= div_r + 5'h01;
                    if (div_r == 5'(see_pkg::CS_GAP_CYC)) begin
                        div_r <= 5'h00;
                        st_r <= H_IDLE;
                        o_ready <= 1'b1;
                    end
                end
                H_IDLE: begin
                    // protect level only moves between frames
                    lnk.reset_pin <= i_prot;
                    if (i_req && rs2_r[1]) begin
                        o_ready <= 1'b0;
                        o_ack <= 1'b1;
                        rd_pend_r <= 1'b0;
                        cmd_r <= see_pkg::see_cmd_type'(i_cmd);
                        sh_r <= {op_of(see_pkg::see_cmd_type'(i_cmd), i_addr), i_addr[7:0], i_wdata};
                        words_r <= (i_nwords == 4'h0) ? 4'h1 : i_nwords;
                        lnk.chip_select_n <= 1'b0;
                        bit_r <= 6'h00;
                        div_r <= 5'h00;
                        st_r <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    div_r <= div_r + 5'h01;
                    if (div_r == 5'(see_pkg::SK_HALF_CYC - 1)) begin
                        lnk.serial_clock_n <= 1'b0;   // falling: present bit
                        lnk.serial_data_in <= sh_r[31];
                    end else if (div_r == 5'(2 * see_pkg::SK_HALF_CYC - 1)) begin
                        div_r <= 5'h00;
                        lnk.serial_clock_n <= 1'b1;   // rising: device samples
                        sh_r <= {sh_r[30:0], 1'b0};
                        // synchronised output lags one link clock: this bit left on the fall before last
                        rx_r <= {rx_r[14:0], rs2_r[0]};
                        bit_r <= bit_r + 6'h01;
                        if (bit_r == 6'(see_pkg::HDR_BITS) && rd_pend_r) begin
                            o_rdata <= {rx_r[14:0], rs2_r[0]};
                            o_rvalid <= 1'b1;
                            rd_pend_r <= 1'b0;
                        end
                        if (bit_r == 6'(see_pkg::FRAME_BITS - 1)) begin
                            rd_pend_r <= (cmd_r == see_pkg::CMD_READ);
                            if ((cmd_r == see_pkg::CMD_PAGE || cmd_r == see_pkg::CMD_READ) && words_r != 4'h1) begin
                                words_r <= words_r - 4'h1;
                                bit_r <= 6'(see_pkg::HDR_BITS);
                                sh_r <= {i_wdata, 16'h0000};
                                o_ack <= (cmd_r == see_pkg::CMD_PAGE);
                            end else begin
                                st_r <= H_TAIL;
                            end
                        end else if (bit_r == 6'(see_pkg::HDR_BITS - 1) &&
                                     (cmd_r == see_pkg::CMD_EN || cmd_r == see_pkg::CMD_DIS)) begin
                            st_r <= H_GAP;
                        end
                    end
                end
                // clock held high while the last read bit crosses the sync
                H_TAIL: begin
                    div_r <= div_r + 5'h01;
                    if (div_r == 5'(see_pkg::SK_HALF_CYC - 1)) begin
                        div_r <= 5'h00;
                        if (rd_pend_r) o_rdata <= {rx_r[14:0], rs2_r[0]};
                        o_rvalid <= rd_pend_r;
                        rd_pend_r <= 1'b0;
                        st_r <= H_GAP;
                    end
                end
                default: st_r <= H_GAP;
            endcase
        end
    end
endmodule // see_host

// >>> core/see_if.sv
`timescale 1ns/100ps
// serial link between host and memory
interface see_if;
    logic chip_select_n;
    logic serial_clock_n;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_out_oe;
    logic reset_pin;
    logic ready_n_busy;
    modport dev (input chip_select_n, serial_clock_n, serial_data_in, reset_pin,
                 output serial_data_out, serial_data_out_oe, ready_n_busy);
    modport hst (output chip_select_n, serial_clock_n, serial_data_in, reset_pin,
                 input serial_data_out, serial_data_out_oe, ready_n_busy);
endinterface

// >>> core/see_pkg.sv
// Function
// - busy output low only during write time-out
// - reset high blocks write and page write
// - reset during time-out aborts programming
// - host raises select after reset first
// - host keeps reset low through writes; this host copies i_prot to reset_pin whenever idle, time-out included
// - read, enable, disable ignore reset level
// - frame is opcode, address, two data bytes
// - select falling with clock high starts frame
// - select high at least 250 ns between frames
// - six opcode bits select, two carry address
// - host never sends factory fill opcode
// - write takes 16 bits, busy on edge 32
// - host may deselect during time-out
// - page write buffers 8 words, starts on deselect
// - host deselects after last bit, before next edge
// - page address increments low three bits only
// - ninth page word overwrites first
// - read drives output from 17th falling edge
// - read advances address, wraps at all ones
// - sample on rising, change on falling edges
// - select falling with clock low gives status
// - programming disabled until enable command
// - early deselect abandons the instruction
package see_pkg;
    localparam int AW = 10;
    localparam int DW = 16;
    localparam int WORDS = 1024;
    localparam int PAGE = 8;
    localparam int CLK_PERIOD_NS = 40;
    localparam int CS_GAP_NS = 250;
    localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SK_HALF_CYC = 4;
    localparam int WRITE_TIME_CYC = 125000;
    localparam int HDR_BITS = 16;
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] OP_WRITE = 6'h29;
    localparam logic [5:0] OP_PAGE = 6'h2D;
    localparam logic [5:0] OP_READ = 6'h2A;
    localparam logic [5:0] OP_CTRL = 6'h28;
    localparam logic [1:0] CTRL_EN = 2'h3;
    localparam logic [1:0] CTRL_DIS = 2'h0;
    localparam logic [7:0] OP_FILL = 8'hAF;
    typedef enum logic [2:0] {CMD_READ, CMD_WRITE, CMD_PAGE, CMD_EN, CMD_DIS} see_cmd_type;
endpackage

// >>> sim/see_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
// host user side driven here, memory end answers over the link
module see_bench;
    localparam int WCYC = 200;
    logic        i_sys_clk;
    logic        i_sys_rst;
    logic        i_req;
    logic [2:0]  i_cmd;
    logic [9:0]  i_addr;
    logic [15:0] i_wdata;
    logic [3:0]  i_nwords;
    logic        i_prot;
    logic        o_ack;
    logic        o_rvalid;
    logic [15:0] o_rdata;
    logic        o_ready;
    logic        o_dev_busy;
    logic        o_busy;
    logic        o_prog_enabled;
    logic [15:0] mdl [0:1023];
    logic [15:0] wbuf [0:15];
    logic [9:0]  wa [0:3] = '{10'h155, 10'h3FF, 10'h000, 10'h0B0};
    logic [31:0] mon_bits;
    int          mon_cnt;
    logic        mon_sk_sel;
    logic        cs_d;
    logic        sk_d;
    int          failures;
    int          num_checks;
    int          i;

    see_if lnk ();
    see_device #(.WRITE_CYC(WCYC)) u_see_device (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .lnk(lnk),
        .o_busy(o_busy), .o_prog_enabled(o_prog_enabled));
    see_host u_see_host (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .lnk(lnk), .i_req(i_req), .i_cmd(i_cmd),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_nwords(i_nwords), .i_prot(i_prot), .o_ack(o_ack),
        .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_ready(o_ready), .o_dev_busy(o_dev_busy));
    see_chk #(.WRITE_CYC(WCYC)) u_see_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .chip_select_n(lnk.chip_select_n), .serial_clock_n(lnk.serial_clock_n),
        .serial_data_in(lnk.serial_data_in), .serial_data_out(lnk.serial_data_out),
        .serial_data_out_oe(lnk.serial_data_out_oe), .reset_pin(lnk.reset_pin), .ready_n_busy(lnk.ready_n_busy));

    // system clock
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // collects data input bits at each rising link clock of a frame
    always @(posedge i_sys_clk) begin
        if (cs_d && !lnk.chip_select_n) begin
            mon_cnt = 0;
            mon_sk_sel = lnk.serial_clock_n;
        end
        if (!sk_d && lnk.serial_clock_n && !lnk.chip_select_n) begin
            mon_bits = {mon_bits[30:0], lnk.serial_data_in};
            mon_cnt++;
        end
        cs_d = lnk.chip_select_n;
        sk_d = lnk.serial_clock_n;
    end

    // verdict and end of run
    task automatic wrap_up();
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // waits for the host to go idle, then lets the device settle
    task automatic settle();
        int t;
        for (t = 0; t < 3000 && o_ready !== 1'b1; t++) @(negedge i_sys_clk);
        `CHK(t < 3000, 1'b1)
        repeat (12) @(negedge i_sys_clk);
    endtask

    // one instruction; page words follow each accept pulse
    task automatic op(input logic [2:0] cmd, input logic [9:0] addr, input int n, input logic prot, input logic upd);
        int k;
        int t;
        @(negedge i_sys_clk);
        for (t = 0; t < 3000 && !(o_ready === 1'b1 && o_dev_busy === 1'b0); t++) @(negedge i_sys_clk);
        i_cmd = cmd;
        i_addr = addr;
        i_nwords = n[3:0];
        i_prot = prot;
        i_wdata = wbuf[0];
        i_req = 1'b1;
        for (k = 0; k < ((cmd == 3'h2) ? n : 1); k++) begin
            for (t = 0; t < 3000 && o_ack !== 1'b1; t++) @(negedge i_sys_clk);
            `CHK(t < 3000, 1'b1)
            i_req = 1'b0;
            i_wdata = wbuf[k + 1];
            if (upd && cmd == 3'h2) mdl[{addr[9:3], addr[2:0] + k[2:0]}] = wbuf[k];
            @(negedge i_sys_clk);
        end
        if (upd && cmd == 3'h1) mdl[addr] = wbuf[0];
        if (cmd != 3'h0) settle();
    endtask

    // sequential read of n words against the model
    task automatic rd(input logic [9:0] addr, input int n, input logic prot);
        int k;
        int t;
        op(3'h0, addr, n, prot, 1'b0);
        for (k = 0; k < n; k++) begin
            for (t = 0; t < 3000 && o_rvalid !== 1'b1; t++) @(negedge i_sys_clk);
            `CHK(o_rdata, mdl[addr + k[9:0]])
            @(negedge i_sys_clk);
        end
        settle();
    endtask

    // main sequence
    initial begin
        failures = 0;
        num_checks = 0;
        i_sys_rst = 1'b1;
        i_req = 1'b0;
        i_cmd = 3'h0;
        i_addr = 10'h000;
        i_wdata = 16'h0000;
        i_nwords = 4'h1;
        i_prot = 1'b0;
        cs_d = 1'b1;
        sk_d = 1'b1;
        mon_cnt = 0;
        mon_bits = 32'h0;
        mon_sk_sel = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        `CHK({lnk.chip_select_n, lnk.ready_n_busy, lnk.serial_data_out_oe, o_prog_enabled}, 4'hC)
        // write before enable is ignored
        wbuf[0] = 16'h1234;
        op(3'h1, 10'h155, 1, 1'b0, 1'b0);
        `CHK(lnk.ready_n_busy, 1'b1)
        op(3'h3, 10'h000, 1, 1'b1, 1'b0);
        `CHK({o_prog_enabled, mon_bits[15:8]}, {1'b1, see_pkg::OP_CTRL, see_pkg::CTRL_EN})
        // protect high blocks the write
        op(3'h1, 10'h155, 1, 1'b1, 1'b0);
        `CHK(lnk.ready_n_busy, 1'b1)
        // plain writes: frame layout and busy
        for (i = 0; i < 4; i++) begin
            wbuf[0] = 16'hA5C3 ^ {6'h00, wa[i]};
            op(3'h1, wa[i], 1, 1'b0, 1'b1);
            `CHK(mon_bits, {see_pkg::OP_WRITE, wa[i], wbuf[0]})
            `CHK({mon_cnt[7:0], mon_sk_sel, lnk.ready_n_busy, o_busy}, {8'h20, 3'h5})
        end
        rd(10'h3FF, 2, 1'b1);
        rd(10'h155, 1, 1'b0);
        // ten page words from offset six wrap onto the first two
        for (i = 0; i < 11; i++) wbuf[i] = 16'h7000 + i[15:0];
        op(3'h2, 10'h0AE, 10, 1'b0, 1'b1);
        `CHK(mon_cnt[7:0], 8'hB0)
        rd(10'h0A8, 9, 1'b0);
        // protect raised mid programming aborts it
        wbuf[0] = 16'h5555;
        op(3'h1, 10'h222, 1, 1'b0, 1'b0);
        `CHK(lnk.ready_n_busy, 1'b0)
        i_prot = 1'b1;
        repeat (6) @(negedge i_sys_clk);
        `CHK({lnk.ready_n_busy, o_busy}, 2'h2)
        // disable then a refused page write
        op(3'h4, 10'h000, 1, 1'b0, 1'b0);
        `CHK(o_prog_enabled, 1'b0)
        op(3'h2, 10'h0A8, 2, 1'b0, 1'b0);
        `CHK(lnk.ready_n_busy, 1'b1)
        rd(10'h0A8, 2, 1'b0);
        wrap_up();
    end

    // watchdog
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        `CHK(1'b0, 1'b1)
        wrap_up();
    end
endmodule // see_bench

// >>> sim/see_chk.sv
`timescale 1ns/100ps
// link checker between host and memory ends
module see_chk #(
    parameter int WRITE_CYC = 200
) (
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    input  wire logic chip_select_n,
    input  wire logic serial_clock_n,
    input  wire logic serial_data_in,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_oe,
    input  wire logic reset_pin,
    input  wire logic ready_n_busy
);
    int busy_cnt_r;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    // length of the current busy stretch
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            busy_cnt_r <= 0;
        end else if (ready_n_busy) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end

    chk_busy_min_len: assert property ($rose(ready_n_busy) && !reset_pin |-> busy_cnt_r >= WRITE_CYC - 1)
        else $error("busy ended early");
    chk_busy_max_len: assert property (!ready_n_busy |-> busy_cnt_r <= WRITE_CYC + 2)
        else $error("busy lasted too long");
    chk_prot_no_busy: assert property ($fell(ready_n_busy) |-> !reset_pin)
        else $error("programming started with protect high");
    chk_abort_ready: assert property (!ready_n_busy && $rose(reset_pin) |-> ##[1:5] ready_n_busy)
        else $error("abort did not return to ready");
    chk_busy_after_rise: assert property ($fell(ready_n_busy) |-> serial_clock_n)
        else $error("busy began away from a rising clock");
    chk_oe_on_fall: assert property ($rose(serial_data_out_oe) |-> !$past(serial_clock_n, 2))
        else $error("output enabled outside clock low phase");
    chk_do_on_low: assert property (serial_data_out_oe && $changed(serial_data_out) |-> !$past(serial_clock_n, 2))
        else $error("output changed while clock high");
    chk_hiz_deselect: assert property (chip_select_n [*4] |-> !serial_data_out_oe)
        else $error("output driven while deselected");
endmodule // see_chk
